// [rtl/drss_pkg.sv]
// Constants and types for the drive ramp and stop sequencer.
// Assumes frequencies in 0.01 Hz units and a 200 MHz system clock.
package drss_pkg;
    // ========================================================================
    // Clock and time base
    // ========================================================================
    localparam int CLK_MHZ = 200;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    localparam logic [13:0] SECT_TICKS = 14'h000a;   // Ticks per 0.1 s
    localparam logic [15:0] DEAD_TICKS = 16'h000a;   // Ticks per 0.1 s

    // ========================================================================
    // Setting limits and documented defaults
    // ========================================================================
    localparam logic [9:0] SECT_MAX = 10'h1f4;           // 50.0 s
    localparam logic [9:0] SECT_DEF = 10'h001;           // 0.1 s
    localparam logic [15:0] STOP_SPD_MAX = 16'h2710;     // 100.00 Hz
    localparam logic [15:0] STOP_SPD_DEF = 16'h0032;     // 0.50 Hz
    localparam logic [15:0] BRAKE_START_DEF = 16'h0000;  // 0.00 Hz
    localparam logic [12:0] DEMAG_DEF = 13'h0000;        // 0.00 s
    localparam logic [9:0] BRAKE_CUR_DEF = 10'h000;      // 0.0 %
    localparam logic [12:0] BRAKE_DUR_DEF = 13'h0000;    // 0.00 s
    localparam logic [9:0] DEAD_DEF = 10'h000;           // 0.0 s

    // ========================================================================
    // Encodings
    // ========================================================================
    localparam logic RAMP_LINEAR = 1'b0;
    localparam logic RAMP_S_CURVE = 1'b1;
    localparam logic STOP_DECEL = 1'b0;
    localparam logic STOP_COAST = 1'b1;
    localparam logic [1:0] REV_AT_ZERO = 2'h0;
    localparam logic [1:0] REV_AT_START = 2'h1;
    localparam logic [1:0] REV_AT_STOP = 2'h2;

    typedef enum logic [5:0] {
        DRSS_IDLE = 6'h01,
        DRSS_RUN = 6'h02,
        DRSS_STOP = 6'h04,
        DRSS_DEMAG = 6'h08,
        DRSS_BRAKE = 6'h10,
        DRSS_DWELL = 6'h20
    } drss_state_t;
endpackage

// [rtl/drss_sequencer.sv]
// Speed-profile ramp generator and stop / DC brake / reversal sequencer.
// Assumes all settings are quasi-static inputs synchronous to ref_clk and
// that the power stage follows out_freq, out_dir, out_enable and brake.
//
// Contract
// [R1] Shape 0 ramps frequency linearly
// [R2] Shape 1 ramps along eased S curve
// [R3] Section times set curvature, 0-50 s
// [R4] Decel stop ramps, cuts at stop speed
// [R5] Coast stop cuts output at once
// [R6] Brake start frequency schedules post-stop brake
// [R7] Demagnetisation wait blocks output before brake
// [R8] Brake level follows programmed brake current
// [R9] Brake held for duration, then ends
// [R10] Reversal dwells at threshold for deadzone
// [R11] Threshold select: zero, start, stop speed
// [R12] Stop speed limited to 0-100 Hz
// [R13] Strict post-stop order, run aborts it
`timescale 1ns/1ps
`default_nettype none
module drss_sequencer #(
    parameter int TICK_CYCLES = drss_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Commands
    input wire logic run_cmd,
    input wire logic dir_cmd,
    input wire logic [15:0] freq_target,
    // Ramp settings
    input wire logic ramp_shape_select,
    input wire logic [15:0] accel_step,
    input wire logic [15:0] decel_step,
    input wire logic [9:0] s_curve_accel_start_time,
    input wire logic [9:0] s_curve_accel_end_time,
    input wire logic [9:0] s_curve_decel_start_time,
    input wire logic [9:0] s_curve_decel_end_time,
    // Stop and brake settings
    input wire logic stop_method_select,
    input wire logic [15:0] stop_speed_threshold,
    input wire logic [15:0] post_stop_brake_start_freq,
    input wire logic [12:0] demagnetisation_wait_time,
    input wire logic [9:0] post_stop_brake_current,
    input wire logic [12:0] post_stop_brake_duration,
    // Reversal settings
    input wire logic [15:0] start_freq,
    input wire logic [9:0] reversal_deadzone_time,
    input wire logic [1:0] reversal_threshold_select,
    // Power stage
    output logic [15:0] out_freq,
    output logic out_dir,
    output logic out_enable,
    output logic brake_active,
    output logic [9:0] brake_level
);
    // ========================================================================
    // Time base
    // ========================================================================
    logic [31:0] tick_cnt;
    wire tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // Every timer shares one 10 ms tick so long times need no wide counters
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) tick_cnt <= 32'h0000_0000;
        else tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end

    // ========================================================================
    // Setting conditioning
    // ========================================================================
    drss_pkg::drss_state_t state, next_state;
    logic [15:0] freq, next_freq, rate, tmr, next_tmr;
    logic [23:0] rem;
    logic dir, next_dir, pend, next_pend;

    // Out-of-range stop speed and section times are clamped rather than trusted
    wire [15:0] stop_spd = (stop_speed_threshold > drss_pkg::STOP_SPD_MAX) ?
        drss_pkg::STOP_SPD_MAX : stop_speed_threshold;  // [R12]
    wire [9:0] as_t = (s_curve_accel_start_time > drss_pkg::SECT_MAX) ?
        drss_pkg::SECT_MAX : s_curve_accel_start_time;  // [R3]
    wire [9:0] ae_t = (s_curve_accel_end_time > drss_pkg::SECT_MAX) ?
        drss_pkg::SECT_MAX : s_curve_accel_end_time;  // [R3]
    wire [9:0] ds_t = (s_curve_decel_start_time > drss_pkg::SECT_MAX) ?
        drss_pkg::SECT_MAX : s_curve_decel_start_time;  // [R3]
    wire [9:0] de_t = (s_curve_decel_end_time > drss_pkg::SECT_MAX) ?
        drss_pkg::SECT_MAX : s_curve_decel_end_time;  // [R3]

    // Reversal threshold decode, undefined code falls back to zero
    wire [15:0] thr = (reversal_threshold_select == drss_pkg::REV_AT_START) ? start_freq :
        (reversal_threshold_select == drss_pkg::REV_AT_STOP) ? stop_spd : 16'h0000;  // [R11]

    // ========================================================================
    // Ramp engine
    // ========================================================================
    wire reversing = (dir_cmd != dir);
    wire [15:0] tgt = (state == drss_pkg::DRSS_RUN) ? (reversing ? thr : freq_target) :
        16'h0000;
    wire up = (freq < tgt);
    wire [15:0] diff = up ? tgt - freq : freq - tgt;
    wire [15:0] full = up ? accel_step : decel_step;
    wire s_mode = (ramp_shape_select == drss_pkg::RAMP_S_CURVE);
    wire [13:0] n_start = 14'(up ? as_t : ds_t) * drss_pkg::SECT_TICKS;  // [R3]
    wire [13:0] n_end = 14'(up ? ae_t : de_t) * drss_pkg::SECT_TICKS;  // [R3]
    // Ease out once the remaining span fits under the falling rate triangle
    wire ease_out = s_mode && (32'({diff, 1'b0}) <= 32'(rate) * 32'(n_end));  // [R2]
    wire [13:0] n_now = ease_out ? n_end : n_start;
    // A floor of one keeps an eased ramp from stalling short of target
    wire [15:0] step = !s_mode ? full : ((rate == 16'h0000) ? 16'h0001 : rate);  // [R1] [R2]
    wire [15:0] mv = (step < diff) ? step : diff;
    wire [15:0] ramp_freq = !tick ? freq : (up ? freq + mv : freq - mv);

    // S-curve rate follows full*k/N, built by repeated subtraction between ticks
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate <= 16'h0000;
            rem <= 24'h00_0000;
        end else if (!s_mode || diff == 16'h0000) begin
            rate <= 16'h0000;
            rem <= 24'h00_0000;
        end else if (n_now == 14'h0000) begin
            rate <= ease_out ? 16'h0000 : full;  // [R3]
            rem <= 24'h00_0000;
        end else if (tick) begin
            rem <= rem + 24'(full);
        end else if (rem >= 24'(n_now)) begin
            rem <= rem - 24'(n_now);
            if (ease_out && rate != 16'h0000) rate <= rate - 16'h0001;  // [R2]
            else if (!ease_out && rate < full) rate <= rate + 16'h0001;  // [R2]
        end
    end

    // ========================================================================
    // Sequencer
    // ========================================================================
    wire tmr_zero = (tmr == 16'h0000);
    wire [15:0] tmr_dec = tick ? tmr - 16'h0001 : tmr;
    wire at_brake_freq = (freq <= post_stop_brake_start_freq);

    // Next-state decode for run, stop, demagnetise, brake and reversal dwell
    always_comb begin
        next_state = state;
        next_freq = freq;
        next_dir = dir;
        next_tmr = tmr;
        next_pend = pend;
        case (state)
            drss_pkg::DRSS_IDLE: begin
                next_freq = 16'h0000;
                if (run_cmd) begin
                    next_state = drss_pkg::DRSS_RUN;
                    next_dir = dir_cmd;
                    next_pend = 1'b0;
                end
            end
            drss_pkg::DRSS_RUN: begin
                next_freq = ramp_freq;
                if (!run_cmd && stop_method_select == drss_pkg::STOP_COAST) begin
                    next_state = drss_pkg::DRSS_IDLE;  // [R5]
                    next_freq = 16'h0000;
                end else if (!run_cmd) begin
                    next_state = drss_pkg::DRSS_STOP;  // [R4]
                    next_pend = 1'b0;
                end else if (reversing && freq <= thr) begin
                    next_state = drss_pkg::DRSS_DWELL;  // [R10]
                    next_freq = freq;
                    next_tmr = 16'(reversal_deadzone_time) * drss_pkg::DEAD_TICKS;
                end
            end
            drss_pkg::DRSS_STOP: begin
                next_freq = ramp_freq;
                if (at_brake_freq) next_pend = 1'b1;  // [R6]
                if (run_cmd) begin
                    next_state = drss_pkg::DRSS_RUN;  // [R13]
                end else if (freq <= stop_spd) begin
                    next_freq = 16'h0000;  // [R4]
                    if ((pend || at_brake_freq) && post_stop_brake_duration != 13'h0000) begin
                        next_state = drss_pkg::DRSS_DEMAG;  // [R13]
                        next_tmr = 16'(demagnetisation_wait_time);
                    end else begin
                        next_state = drss_pkg::DRSS_IDLE;
                    end
                end
            end
            drss_pkg::DRSS_DEMAG: begin
                if (run_cmd) begin
                    next_state = drss_pkg::DRSS_RUN;  // [R13]
                    next_dir = dir_cmd;
                end else if (tmr_zero) begin
                    next_state = drss_pkg::DRSS_BRAKE;  // [R7]
                    next_tmr = 16'(post_stop_brake_duration);
                end else begin
                    next_tmr = tmr_dec;  // [R7]
                end
            end
            drss_pkg::DRSS_BRAKE: begin
                if (run_cmd) begin
                    next_state = drss_pkg::DRSS_RUN;  // [R13]
                    next_dir = dir_cmd;
                end else if (tmr_zero) begin
                    next_state = drss_pkg::DRSS_IDLE;  // [R9]
                end else begin
                    next_tmr = tmr_dec;  // [R9]
                end
            end
            drss_pkg::DRSS_DWELL: begin
                if (!run_cmd) begin
                    // A flag left by an aborted stop must not brake this one
                    next_pend = 1'b0;  // [R13]
                    next_state = (stop_method_select == drss_pkg::STOP_COAST) ?
                        drss_pkg::DRSS_IDLE : drss_pkg::DRSS_STOP;
                    if (stop_method_select == drss_pkg::STOP_COAST) next_freq = 16'h0000;
                end else if (tmr_zero) begin
                    next_state = drss_pkg::DRSS_RUN;  // [R10]
                    next_dir = dir_cmd;
                end else begin
                    next_tmr = tmr_dec;  // [R10]
                end
            end
            default: next_state = drss_pkg::DRSS_IDLE;
        endcase
    end

    // Output stage follows the next state so outputs line up with the state
    wire next_drive = (next_state == drss_pkg::DRSS_RUN) ||
        (next_state == drss_pkg::DRSS_STOP) || (next_state == drss_pkg::DRSS_DWELL);
    wire next_brake = (next_state == drss_pkg::DRSS_BRAKE);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= drss_pkg::DRSS_IDLE;
            freq <= 16'h0000;
            dir <= 1'b0;
            tmr <= 16'h0000;
            pend <= 1'b0;
        end else begin
            state <= next_state;
            freq <= next_freq;
            dir <= next_dir;
            tmr <= next_tmr;
            pend <= next_pend;
        end
    end

    // Registered drive to the power stage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_enable <= 1'b0;
            brake_active <= 1'b0;
            brake_level <= 10'h000;
        end else begin
            out_enable <= next_drive;  // [R5] [R7]
            brake_active <= next_brake;  // [R9]
            brake_level <= next_brake ? post_stop_brake_current : 10'h000;  // [R8]
        end
    end

    assign out_freq = freq;
    assign out_dir = dir;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    wire in_run = (state == drss_pkg::DRSS_RUN);

    a_linear_step: assert property (tick && in_run && run_cmd && !reversing && !s_mode  // [R1]
        && up && diff >= accel_step |=> out_freq == $past(out_freq) + $past(accel_step))
        else $error("linear ramp step wrong");
    a_s_soft_start: assert property (tick && in_run && run_cmd && s_mode  // [R2]
        && rate == 16'h0000
        |=> (out_freq - $past(out_freq) <= 16'h0001) || ($past(out_freq) - out_freq <= 16'h0001))
        else $error("s curve did not ease in");
    a_sect_zero: assert property (s_mode && diff != 16'h0000 && n_now == 14'h0000  // [R3]
        && !ease_out |=> rate == $past(full))
        else $error("zero section time not immediate");
    a_decel_cut: assert property (state == drss_pkg::DRSS_STOP && !run_cmd  // [R4]
        && freq <= stop_spd |=> !out_enable && out_freq == 16'h0000)
        else $error("decel stop did not cut output");
    a_coast_cut: assert property (in_run && !run_cmd  // [R5]
        && stop_method_select == drss_pkg::STOP_COAST |=> !out_enable ##1 !out_enable)
        else $error("coast stop kept output");
    a_brake_sched: assert property (state == drss_pkg::DRSS_STOP && at_brake_freq  // [R6]
        && !run_cmd |=> pend || state != drss_pkg::DRSS_STOP)
        else $error("brake not scheduled");
    a_demag_block: assert property (state == drss_pkg::DRSS_DEMAG |-> !out_enable && !brake_active)  // [R7]
        else $error("output during demagnetisation");
    a_brake_level: assert property (!brake_active |-> brake_level == 10'h000)  // [R8]
        else $error("brake level without brake");
    a_brake_end: assert property (state == drss_pkg::DRSS_BRAKE && tmr_zero && !run_cmd  // [R9]
        |=> !brake_active && state == drss_pkg::DRSS_IDLE)
        else $error("brake did not end");
    a_dwell_hold: assert property (state == drss_pkg::DRSS_DWELL && run_cmd && !tmr_zero  // [R10]
        |=> $stable(out_freq) && $stable(out_dir))
        else $error("dwell did not hold");
    // Dwell is only reached at or below the threshold that the select code names
    a_thr_decode: assert property (state == drss_pkg::DRSS_DWELL  // [R11]
        |-> (reversal_threshold_select == drss_pkg::REV_AT_START) ? out_freq <= start_freq :
        (reversal_threshold_select == drss_pkg::REV_AT_STOP) ? out_freq <= stop_spd :
        out_freq == 16'h0000)
        else $error("threshold decode wrong");
    // A stop above the top of the stop-speed range must keep ramping
    a_stop_clamp: assert property (state == drss_pkg::DRSS_STOP && !run_cmd  // [R12]
        && freq > drss_pkg::STOP_SPD_MAX |=> out_enable)
        else $error("stop speed not clamped");
    a_abort_run: assert property ((state == drss_pkg::DRSS_DEMAG  // [R13]
        || state == drss_pkg::DRSS_BRAKE) && run_cmd |=> state == drss_pkg::DRSS_RUN)
        else $error("run did not abort stop sequence");

    c_full_brake: cover property (state == drss_pkg::DRSS_DEMAG ##[1:100] brake_active);
    c_reversal: cover property (state == drss_pkg::DRSS_DWELL ##1 in_run);
    c_coast: cover property (in_run && !run_cmd && stop_method_select);
    c_s_ease: cover property (in_run && ease_out && rate != 16'h0000);
endmodule
`default_nettype wire

// [sim/drss_motor_model.sv]
// Behavioural power stage plus motor shaft, fed by the sequencer outputs.
// Assumes the same ref_clk and rst_b as the sequencer; speed in 0.01 Hz.
`timescale 1ns/1ps
`default_nettype none
module drss_motor_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Power stage drive
    input wire logic [15:0] out_freq,
    input wire logic out_enable,
    input wire logic brake_active,
    input wire logic [9:0] brake_level,
    // Shaft speed
    output logic [15:0] motor_speed
);
    logic [15:0] decay;
    // Coasting loses one unit a cycle; DC brake adds its level on top
    assign decay = brake_active ? 16'h0001 + {6'h00, brake_level} : 16'h0001;
    // Driven shaft locks to the stator, otherwise it runs down by decay, brake level included
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            motor_speed <= 16'h0000;
        end else if (out_enable) begin
            motor_speed <= out_freq;
        end else begin
            motor_speed <= (motor_speed > decay) ? motor_speed - decay : 16'h0000;
        end
    end
endmodule
`default_nettype wire

// [sim/tb_drive_ramp_stop_sequencer.sv]
// Self-checking bench for the ramp and stop sequencer with a motor model.
// Assumes a shortened tick of 8 cycles; section and deadzone unit is 10 ticks.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_ramp_stop_sequencer;
    localparam int TK = 8;
    logic ref_clk = 1'b0, rst_b = 1'b0, run_cmd = 1'b0, dir_cmd = 1'b0, shape = 1'b0;
    logic stop_m = 1'b0, out_dir, out_enable, brake_active;
    logic [15:0] tgt = 16'h0064, acc = 16'h001e, dec = 16'h001e, stop_spd = 16'h0032;
    logic [15:0] bstart = 16'h002d, start_f = 16'h0014, out_freq, motor_speed, f, pf;
    logic [12:0] demag = 13'h0002, bdur = 13'h0003;
    logic [9:0] sect = 10'h001, bcur = 10'h123, dead = 10'h001, brake_level;
    logic [1:0] rsel = 2'h0;
    logic [15:0] prev_freq = 16'h0000;
    int bad_count = 0, check_count = 0, stable = 0, n, i;
    // ========================================================================
    // Clock, design and partner
    // ========================================================================
    always #2.5 ref_clk = ~ref_clk;
    drss_sequencer #(.TICK_CYCLES(TK)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .run_cmd(run_cmd), .dir_cmd(dir_cmd), .freq_target(tgt), .ramp_shape_select(shape),
        .accel_step(acc), .decel_step(dec), .s_curve_accel_start_time(sect),
        .s_curve_accel_end_time(sect), .s_curve_decel_start_time(sect),
        .s_curve_decel_end_time(sect), .stop_method_select(stop_m),
        .stop_speed_threshold(stop_spd), .post_stop_brake_start_freq(bstart),
        .demagnetisation_wait_time(demag), .post_stop_brake_current(bcur),
        .post_stop_brake_duration(bdur), .start_freq(start_f),
        .reversal_deadzone_time(dead), .reversal_threshold_select(rsel),
        .out_freq(out_freq), .out_dir(out_dir), .out_enable(out_enable),
        .brake_active(brake_active), .brake_level(brake_level));
    drss_motor_model partner (.ref_clk(ref_clk), .rst_b(rst_b), .out_freq(out_freq),
        .out_enable(out_enable), .brake_active(brake_active), .brake_level(brake_level),
        .motor_speed(motor_speed));
    // Cycles since out_freq last moved, to measure dwell times
    always @(posedge ref_clk) begin
        stable <= (out_freq !== prev_freq) ? 0 : stable + 1;
        prev_freq <= out_freq;
    end
    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cmp_range(input string nm, input int lo, input int hi, input logic [31:0] got);
        check_count++;
        // An unknown value must never slip through as a pass
        if ($isunknown(got) || got < lo || got > hi) begin
            bad_count++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    // Sample just after the edge so that the edge's updates have landed
    task automatic step(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic hang();
        bad_count++;
        $display("MISMATCH wait expected event seen timeout");
        complete_run();
    endtask
    // Waits for the next change of out_freq and returns the new value
    task automatic wait_freq(output logic [15:0] v);
        logic [15:0] old;
        int k;
        old = out_freq;
        for (k = 0; k < 4000 && out_freq === old; k++) step(1);
        if (out_freq === old) hang();
        v = out_freq;
    endtask
    function automatic logic sel(input int w);
        return (w == 0) ? out_dir : (w == 1) ? brake_active : out_enable;
    endfunction
    // Waits until output w (0 dir, 1 brake, 2 enable) shows lvl; c counts cycles
    task automatic wait_for(input int w, input logic lvl, output int c);
        for (c = 0; c < 4000 && sel(w) !== lvl; c++) step(1);
        if (sel(w) !== lvl) hang();
    endtask
    // ========================================================================
    // Scenarios
    // ========================================================================
    initial begin
        step(10);
        cmp_val("reset_enable", 16'h0000, {15'h0000, out_enable});
        @(posedge ref_clk) rst_b <= 1'b1;
        @(posedge ref_clk) run_cmd <= 1'b1;
        step(1);
        cmp_val("start_enable", 16'h0001, {15'h0000, out_enable});
        cmp_val("start_freq", 16'h0000, out_freq);
        // Linear ramp in equal steps, last one trimmed to the target
        for (i = 1; i <= 4; i++) begin
            wait_freq(f);
            cmp_val("lin_freq", (i < 4) ? 16'(30 * i) : 16'h0064, f);
        end
        // Decelerating stop through demagnetisation wait into DC brake
        @(posedge ref_clk) run_cmd <= 1'b0;
        for (i = 0; i < 3; i++) begin
            wait_freq(f);
            cmp_val("dec_freq", (i < 2) ? 16'(70 - 30 * i) : 16'h0000, f);
        end
        cmp_val("dec_enable", 16'h0000, {15'h0000, out_enable});
        wait_for(1, 1'b1, n);
        cmp_range("demag_cycles", 2 * TK - 8, 3 * TK + 2, n);
        cmp_val("brake_level", 16'h0123, {6'h00, brake_level});
        wait_for(1, 1'b0, n);
        cmp_range("brake_cycles", 2 * TK + 1, 3 * TK + 2, n + 1);
        cmp_val("brake_off_level", 16'h0000, {6'h00, brake_level});
        // Coast stop: output cut at once while the shaft keeps turning
        @(posedge ref_clk) run_cmd <= 1'b1;
        acc <= 16'h0064;
        wait_freq(f);
        @(posedge ref_clk) stop_m <= 1'b1;
        run_cmd <= 1'b0;
        step(1);
        cmp_val("coast_freq", 16'h0000, out_freq);
        cmp_val("coast_enable", 16'h0000, {15'h0000, out_enable});
        cmp_range("coast_shaft", 90, 100, 32'(motor_speed));
        // Reversal at each threshold select, dwelling for the deadzone
        @(posedge ref_clk) stop_m <= 1'b0;
        run_cmd <= 1'b1;
        acc <= 16'h001e;
        for (i = 0; i < 3; i++) begin
            for (n = 0; n < 100 && out_freq !== 16'h0064; n++) wait_freq(f);
            cmp_val("rev_top", 16'h0064, out_freq);
            @(posedge ref_clk) rsel <= 2'(i);
            dir_cmd <= ~dir_cmd;
            // Let the new direction land before it is handed to the wait
            step(1);
            wait_for(0, dir_cmd, n);
            cmp_range("rev_freq", 0, (i == 0) ? 0 : (i == 1) ? 20 : 50, 32'(out_freq));
            cmp_range("rev_dwell", 10 * TK - 10, 10 * TK + 10, stable);
        end
        // S curve eases in and out, then a stop is aborted while braking
        @(posedge ref_clk) shape <= 1'b1;
        tgt <= 16'h03e8;
        pf = out_freq;
        wait_freq(f);
        cmp_range("s_first_step", 1, 29, 32'(f - pf));
        for (n = 0; n < 200 && f !== 16'h03e8; n++) begin
            pf = f;
            wait_freq(f);
        end
        cmp_val("s_target", 16'h03e8, f);
        cmp_range("s_last_step", 1, 29, 32'(f - pf));
        // Zero section times make the eased stop take the full rate at once
        @(posedge ref_clk) run_cmd <= 1'b0;
        sect <= 10'h000;
        wait_for(1, 1'b1, n);
        @(posedge ref_clk) run_cmd <= 1'b1;
        step(1);
        cmp_val("abort_brake", 16'h0000, {15'h0000, brake_active});
        cmp_val("abort_enable", 16'h0001, {15'h0000, out_enable});
        // Stop speed above its range is held at 100.00 Hz
        @(posedge ref_clk) shape <= 1'b0;
        acc <= 16'h1388;
        dec <= 16'h1388;
        tgt <= 16'h4e20;
        for (n = 0; n < 20 && out_freq !== 16'h4e20; n++) wait_freq(f);
        cmp_val("clamp_top", 16'h4e20, out_freq);
        @(posedge ref_clk) stop_spd <= 16'hffff;
        run_cmd <= 1'b0;
        wait_freq(f);
        cmp_val("clamp_freq", 16'h3a98, f);
        complete_run();
    end
endmodule
`default_nettype wire
